// ==== shared/frame_protect_regs.svh ====
// Offsets, field positions, reset values and address ranges of the decoder
`ifndef FRAME_PROTECT_REGS_SVH
`define FRAME_PROTECT_REGS_SVH

// ----------------------------------------------------------------
// Peripheral frames (22-bit word addresses)
// ----------------------------------------------------------------
`define FR0_LO 22'h000800
`define FR0_HI 22'h000fff
`define FR1_LO 22'h006000
`define FR1_HI 22'h006fff
`define FR2_LO 22'h007000
`define FR2_HI 22'h007fff

// ----------------------------------------------------------------
// Guarded regions inside frame zero
// ----------------------------------------------------------------
`define EMU_LO 22'h000800
`define EMU_HI 22'h00087f
`define DEVEMU_LO 22'h000880
`define DEVEMU_HI 22'h0009ff
`define FLASH_LO 22'h000a80
`define FLASH_HI 22'h000adf
`define SECREG_LO 22'h000ae0
`define SECREG_HI 22'h000aef

// ----------------------------------------------------------------
// Local register words
// ----------------------------------------------------------------
`define CFG_LO_ADDR 22'h000880
`define CFG_HI_ADDR 22'h000881
`define IDENT_LO_ADDR 22'h000882
`define IDENT_HI_ADDR 22'h000883
`define WIN_BASE_ADDR 22'h000884
`define WIN_SIZE_ADDR 22'h000885

// ----------------------------------------------------------------
// Configuration fields and reset values
// ----------------------------------------------------------------
`define CFG_VECMAP_BIT 3
`define CFG_RSTPIN_BIT 5
`define CFG_ORDER_BIT 19
`define CFG_RW_MASK 32'h0008_8083
`define CFG_ONES 32'h0007_0040
`define CFG_RESET 32'h0008_0003
`define WIN_BASE_RESET 16'h0100
`define WIN_SIZE_RESET 16'h00ff
`define WIN_GRAIN_BITS 6

`endif

// ==== shared/frame_protect_pkg.sv ====
// Types shared by the frame decoder and the protection controller
package frame_protect_pkg;

    // Which peripheral frame an address falls in
    typedef enum logic [1:0] {FR_NONE, FR_ZERO, FR_ONE, FR_TWO} frame_t;

    // Decode result for one word address
    typedef struct packed {
        frame_t frame;
        logic hole;
        logic wprot;
        logic sec_guard;
        logic local_reg;
    } decode_t;

    // One bus access
    typedef struct packed {
        logic write;
        logic wide;
        logic [21:0] addr;
        logic [31:0] wdata;
    } access_t;

    // Downstream channel state
    typedef enum logic [1:0] {DN_IDLE, DN_READ, DN_WRITE} dn_state_t;

endpackage : frame_protect_pkg

// ==== logic/frame_decode.sv ====
// Address decoder for the three peripheral frames
`timescale 1ns/1ns
`include "frame_protect_regs.svh"

module frame_decode
    import frame_protect_pkg::*;
(
    // Word address of the access
    input wire logic [21:0] addr,
    // Decode result
    output decode_t dec
);

    // ----------------------------------------------------------------
    // Populated spans besides the guarded ones: low, high, protected
    // ----------------------------------------------------------------
    localparam int NR = 13;
    localparam logic [44:0] SPAN [NR] = '{
        {22'h000b20, 22'h000b3f, 1'b0},
        {22'h000c00, 22'h000c3f, 1'b0},
        {22'h000ce0, 22'h000cff, 1'b0},
        {22'h000d00, 22'h000dff, 1'b1},
        {22'h006000, 22'h0061ff, 1'b0},
        {22'h007010, 22'h00702f, 1'b1},
        {22'h007040, 22'h00705f, 1'b0},
        {22'h007070, 22'h00707f, 1'b0},
        {22'h0070c0, 22'h0070df, 1'b1},
        {22'h0070e0, 22'h00711f, 1'b0},
        {22'h007400, 22'h00743f, 1'b0},
        {22'h007500, 22'h00753f, 1'b0},
        {22'h007750, 22'h00783f, 1'b0}
    };

    // Frame, hole and guard flags
    always_comb
    begin
        dec = '0;
        if (addr >= `FR0_LO && addr <= `FR0_HI)
            dec.frame = FR_ZERO;
        else if (addr >= `FR1_LO && addr <= `FR1_HI)
            dec.frame = FR_ONE;
        else if (addr >= `FR2_LO && addr <= `FR2_HI)
            dec.frame = FR_TWO;
        dec.hole = (dec.frame != FR_NONE);
        if (addr >= `EMU_LO && addr <= `EMU_HI)
        begin
            dec.hole = 1'b0;
            dec.wprot = 1'b1;
        end
        if (addr >= `CFG_LO_ADDR && addr <= `WIN_SIZE_ADDR)
        begin
            dec.hole = 1'b0;
            dec.local_reg = 1'b1;
        end
        if (addr >= `DEVEMU_LO && addr <= `DEVEMU_HI)
            dec.wprot = 1'b1;
        if (addr >= `FLASH_LO && addr <= `FLASH_HI)
        begin
            dec.hole = 1'b0;
            dec.wprot = 1'b1;
            dec.sec_guard = 1'b1;
        end
        if (addr >= `SECREG_LO && addr <= `SECREG_HI)
        begin
            dec.hole = 1'b0;
            dec.wprot = 1'b1;
        end
        for (int i = 0; i < NR; i++)
        begin
            if (addr >= SPAN[i][44:23] && addr <= SPAN[i][22:1])
            begin
                dec.hole = 1'b0;
                dec.wprot = dec.wprot | SPAN[i][0];
            end
        end
    end

endmodule : frame_decode

// ==== logic/peripheral_frame_decode_protect.sv ====
// Frame decode, write protection and write-read ordering controller
`timescale 1ns/1ns
`include "frame_protect_regs.svh"


module peripheral_frame_decode_protect
    import frame_protect_pkg::*;
#(
    parameter logic [15:0] PART_CODE = 16'h5a3c, // Arbitrary value
    parameter logic [15:0] REV_CODE = 16'h00a7 // Arbitrary value
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Processor access, held until acknowledged
    input wire logic cpu_req,
    input access_t cpu_acc,
    output logic cpu_ack,
    output logic [31:0] cpu_rdata,
    output logic cpu_rejected,
    // Instruction strobes and status levels
    input wire logic write_allow_instr,
    input wire logic write_disallow_instr,
    input wire logic reset_pin_status,
    input wire logic vector_map_config,
    input wire logic security_locked,
    output logic write_allow,
    // Peripheral side, held until done
    output logic per_req,
    output access_t per_acc,
    input wire logic per_done,
    input wire logic [31:0] per_rdata
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic allow_q;
    logic [31:0] cfg_q;
    logic [15:0] base_q;
    logic [15:0] size_q;
    logic pw_valid_q;
    access_t pw_q;
    dn_state_t dn_q;
    logic per_req_q;
    access_t per_acc_q;
    logic rd_pend_q;
    logic cpu_ack_q;
    logic [31:0] cpu_rdata_q;
    logic cpu_rejected_q;

    // ----------------------------------------------------------------
    // Decode and access classification
    // ----------------------------------------------------------------
    decode_t dec;
    logic take;
    logic bad_width;
    logic sec_block;
    logic wr_block;
    logic to_per;
    logic in_win;
    logic ordering_protect_enable;
    logic rd_issue;
    logic wr_issue;
    logic wr_post;
    logic [31:0] cfg_view;
    logic [31:0] local_rd;

    frame_decode u_decode (
        .addr(cpu_acc.addr),
        .dec(dec)
    );

    // Access gating
    assign take = cpu_req && !cpu_ack_q && !rd_pend_q;
    assign bad_width = (dec.frame == FR_TWO) && cpu_acc.wide;
    assign sec_block = dec.sec_guard && security_locked;
    assign wr_block = (dec.wprot && !allow_q) || sec_block;
    assign to_per = !dec.hole && !bad_width && !dec.local_reg
        && !sec_block;
    assign ordering_protect_enable = cfg_q[`CFG_ORDER_BIT];
    assign in_win = ((cpu_acc.addr[21:`WIN_GRAIN_BITS] ^ base_q)
        & ~size_q) == 16'h0000;

    // Read may pass a posted write only outside an enabled window
    assign rd_issue = take && !cpu_acc.write && to_per
        && dn_q == DN_IDLE
        && !(ordering_protect_enable && in_win && pw_valid_q);
    assign wr_post = take && cpu_acc.write && to_per && !wr_block
        && !pw_valid_q;
    assign wr_issue = dn_q == DN_IDLE && pw_valid_q && !rd_issue;

    // Configuration view with fixed and live bits
    always_comb
    begin
        cfg_view = (cfg_q & `CFG_RW_MASK) | `CFG_ONES;
        cfg_view[`CFG_VECMAP_BIT] = vector_map_config;
        cfg_view[`CFG_RSTPIN_BIT] = reset_pin_status;
    end

    // Local word read; 32-bit reads take the following word on top
    always_comb
    begin
        logic [21:0] wa;
        logic [15:0] w;
        local_rd = 32'h0000_0000;
        wa = cpu_acc.addr;
        w = 16'h0000;
        for (int k = 0; k < 2; k++)
        begin
            wa = cpu_acc.addr + 22'(k);
            unique case (wa)
                `CFG_LO_ADDR: w = cfg_view[15:0];
                `CFG_HI_ADDR: w = cfg_view[31:16];
                `IDENT_LO_ADDR: w = PART_CODE;
                `IDENT_HI_ADDR: w = REV_CODE;
                `WIN_BASE_ADDR: w = base_q;
                `WIN_SIZE_ADDR: w = size_q;
                default: w = 16'h0000;
            endcase
            if (k == 0)
                local_rd[15:0] = w;
            else if (cpu_acc.wide)
                local_rd[31:16] = w;
        end
        if (!dec.local_reg || bad_width)
            local_rd = 32'h0000_0000;
    end

    // ----------------------------------------------------------------
    // Write-allow state
    // ----------------------------------------------------------------
    // Allow strobe wins when both arrive together
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            allow_q <= 1'b0;
        else if (write_allow_instr)
            allow_q <= 1'b1;
        else if (write_disallow_instr)
            allow_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Local registers
    // ----------------------------------------------------------------
    // Word writes; a 32-bit write also fills the following word
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cfg_q <= `CFG_RESET;
            base_q <= `WIN_BASE_RESET;
            size_q <= `WIN_SIZE_RESET;
        end
        else if (take && cpu_acc.write && dec.local_reg && !wr_block)
        begin
            for (int k = 0; k < 2; k++)
            begin
                if (k == 0 || cpu_acc.wide)
                begin
                    unique case (cpu_acc.addr + 22'(k))
                        `CFG_LO_ADDR: cfg_q[15:0] <=
                            cpu_acc.wdata[16*k +: 16];
                        `CFG_HI_ADDR: cfg_q[31:16] <=
                            cpu_acc.wdata[16*k +: 16];
                        `WIN_BASE_ADDR: base_q <=
                            cpu_acc.wdata[16*k +: 16];
                        `WIN_SIZE_ADDR: size_q <=
                            cpu_acc.wdata[16*k +: 16];
                        default: ;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Posted write buffer
    // ----------------------------------------------------------------
    // One-deep store; emptied when its peripheral write completes
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pw_valid_q <= 1'b0;
            pw_q <= '0;
        end
        else if (wr_post)
        begin
            pw_valid_q <= 1'b1;
            pw_q <= cpu_acc;
        end
        else if (dn_q == DN_WRITE && per_done)
            pw_valid_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Peripheral channel
    // ----------------------------------------------------------------
    // Frame-one 32-bit words go out as given, even address assumed
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            dn_q <= DN_IDLE;
            per_req_q <= 1'b0;
            per_acc_q <= '0;
        end
        else
        begin
            unique case (dn_q)
                DN_IDLE:
                begin
                    if (rd_issue)
                    begin
                        dn_q <= DN_READ;
                        per_req_q <= 1'b1;
                        per_acc_q <= cpu_acc;
                    end
                    else if (wr_issue)
                    begin
                        dn_q <= DN_WRITE;
                        per_req_q <= 1'b1;
                        per_acc_q <= pw_q;
                    end
                end
                DN_READ, DN_WRITE:
                begin
                    if (per_done)
                    begin
                        dn_q <= DN_IDLE;
                        per_req_q <= 1'b0;
                    end
                end
                default: dn_q <= DN_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Processor answer
    // ----------------------------------------------------------------
    // Acknowledge local, dropped and posted accesses; finish reads
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cpu_ack_q <= 1'b0;
            cpu_rdata_q <= 32'h0000_0000;
            cpu_rejected_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end
        else
        begin
            cpu_ack_q <= 1'b0;
            cpu_rejected_q <= 1'b0;
            if (take && cpu_acc.write)
            begin
                if (!to_per || wr_block)
                begin
                    cpu_ack_q <= 1'b1;
                    cpu_rejected_q <= wr_block;
                end
                else if (wr_post)
                    cpu_ack_q <= 1'b1;
            end
            else if (take && !to_per)
            begin
                cpu_ack_q <= 1'b1;
                cpu_rdata_q <= local_rd;
            end
            else if (rd_issue)
                rd_pend_q <= 1'b1;
            if (rd_pend_q && dn_q == DN_READ && per_done)
            begin
                rd_pend_q <= 1'b0;
                cpu_ack_q <= 1'b1;
                cpu_rdata_q <= per_acc_q.wide ? per_rdata
                    : {16'h0000, per_rdata[15:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign cpu_ack = cpu_ack_q;
    assign cpu_rdata = cpu_rdata_q;
    assign cpu_rejected = cpu_rejected_q;
    assign write_allow = allow_q;
    assign per_req = per_req_q;
    assign per_acc = per_acc_q;

endmodule : peripheral_frame_decode_protect

// ==== bench/frame_protect_monitor.sv ====
// Concurrent checks on the frame decoder and protection ports
`timescale 1ns/1ns
`include "frame_protect_regs.svh"

module frame_protect_monitor
    import frame_protect_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Processor side
    input access_t cpu_acc,
    input wire logic cpu_ack,
    input wire logic [31:0] cpu_rdata,
    input wire logic cpu_rejected,
    // Strobes and levels
    input wire logic write_allow_instr,
    input wire logic write_disallow_instr,
    input wire logic reset_pin_status,
    input wire logic vector_map_config,
    input wire logic security_locked,
    input wire logic write_allow,
    // Peripheral side
    input wire logic per_req,
    input access_t per_acc,
    input wire logic per_done,
    input wire logic [31:0] per_rdata
);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // Accepted write to frame one registers
    sequence s_post_wr;
        cpu_ack && cpu_acc.write && !cpu_rejected
            && cpu_acc.addr inside {[`FR1_LO:22'h0061ff]};
    endsequence
    // Finished read from frame one
    sequence s_pf1_rd;
        per_req && per_done && !per_acc.write
            && per_acc.addr inside {[`FR1_LO:`FR1_HI]};
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_allow_set: assert property (
        write_allow_instr |=> write_allow)
        else $error("write allow not set");
    a_allow_clr: assert property (
        write_disallow_instr && !write_allow_instr |=> !write_allow)
        else $error("write allow not cleared");
    a_guard_rej: assert property (
        cpu_ack && cpu_acc.write && !$past(write_allow)
        && cpu_acc.addr inside {[`EMU_LO:`EMU_HI], [`SECREG_LO:`SECREG_HI]}
        |-> cpu_rejected)
        else $error("guarded write not rejected");
    a_flash_lock: assert property (
        cpu_ack && cpu_acc.write && $past(security_locked)
        && cpu_acc.addr inside {[`FLASH_LO:`FLASH_HI]} |-> cpu_rejected)
        else $error("locked flash write not rejected");
    a_rej_ack: assert property (
        cpu_rejected |-> cpu_ack && cpu_acc.write)
        else $error("reject without write ack");
    a_f2_narrow: assert property (
        per_req |-> !(per_acc.wide && per_acc.addr inside {[`FR2_LO:`FR2_HI]}))
        else $error("wide frame two access passed on");
    a_f2_wide_rd: assert property (
        cpu_ack && !cpu_acc.write && cpu_acc.wide
        && cpu_acc.addr inside {[`FR2_LO:`FR2_HI]} |-> cpu_rdata == 32'h0)
        else $error("wide frame two read not zero");
    a_cfg_view: assert property (
        cpu_ack && !cpu_acc.write && cpu_acc.addr == `CFG_LO_ADDR
        |-> cpu_rdata[5] == $past(reset_pin_status) && cpu_rdata[6]
        && cpu_rdata[3] == $past(vector_map_config) && !cpu_rdata[4])
        else $error("config view wrong");
    a_rd_answer: assert property (
        s_pf1_rd |=> cpu_ack
        && (!cpu_acc.wide || cpu_rdata == $past(per_rdata)))
        else $error("frame one read not answered");
    a_post_issue: assert property (
        s_post_wr |-> ##[1:40] (per_req && per_acc.write))
        else $error("posted write not issued");
endmodule : frame_protect_monitor

bind peripheral_frame_decode_protect frame_protect_monitor i_mon (
    .ref_clk(ref_clk),
    .srst(srst),
    .cpu_acc(cpu_acc),
    .cpu_ack(cpu_ack),
    .cpu_rdata(cpu_rdata),
    .cpu_rejected(cpu_rejected),
    .write_allow_instr(write_allow_instr),
    .write_disallow_instr(write_disallow_instr),
    .reset_pin_status(reset_pin_status),
    .vector_map_config(vector_map_config),
    .security_locked(security_locked),
    .write_allow(write_allow),
    .per_req(per_req),
    .per_acc(per_acc),
    .per_done(per_done),
    .per_rdata(per_rdata)
);

// ==== bench/periph_model.sv ====
// Behavioural peripheral that answers decoder accesses
`timescale 1ns/1ns

module periph_model
    import frame_protect_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Wait cycles before each access completes
    input wire logic [3:0] lat,
    // Access from the decoder
    input wire logic per_req,
    input access_t per_acc,
    output logic per_done,
    output logic [31:0] per_rdata
);
    logic [15:0] mem [logic [21:0]];
    logic [3:0] cnt_q;
    logic [21:0] a;
    logic [15:0] lo;
    logic [15:0] hi;

    // ----------------------------------------
    // Answer each access after lat cycles
    // ----------------------------------------
    initial
    begin
        per_done = 1'b0;
        per_rdata = 32'h0;
        cnt_q = 4'h0;
    end
    always @(posedge ref_clk)
    begin
        a = per_acc.addr;
        per_done <= 1'b0;
        per_rdata <= ~per_rdata; // Data only valid with done
        if (srst || !per_req || per_done)
            cnt_q <= 4'h0;
        else if (cnt_q != lat)
            cnt_q <= cnt_q + 4'h1;
        else
        begin
            per_done <= 1'b1;
            if (per_acc.write)
            begin
                mem[a] = per_acc.wdata[15:0];
                if (per_acc.wide)
                    mem[a + 22'h1] = per_acc.wdata[31:16];
            end
            lo = mem.exists(a) ? mem[a] : 16'h0;
            hi = mem.exists(a + 22'h1) ? mem[a + 22'h1] : 16'h0;
            per_rdata <= {per_acc.wide ? hi : ~lo, lo};
        end
    end
endmodule : periph_model

// ==== bench/test_peripheral_frame_decode_protect.sv ====
// Self-checking bench for the frame decoder and protection block
`timescale 1ns/1ns
`include "frame_protect_regs.svh"

`define CHK(nm, e, g) \
    begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end

module test_peripheral_frame_decode_protect
    import frame_protect_pkg::*;
;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic cpu_req = 1'b0;
    access_t cpu_acc = '0;
    logic write_allow_instr = 1'b0;
    logic write_disallow_instr = 1'b0;
    logic reset_pin_status = 1'b1;
    logic vector_map_config = 1'b0;
    logic security_locked = 1'b0;
    logic [3:0] lat = 4'h3;
    logic cpu_ack, cpu_rejected, write_allow, per_req, per_done, rj_v;
    logic [31:0] cpu_rdata, per_rdata, rd_v;
    access_t per_acc;
    logic [21:0] ga [7] = '{22'h800, 22'h87f, 22'ha80, 22'hadf,
        22'hae0, 22'haef, 22'haf0};
    logic [6:0] gx = 7'b0111111;
    logic [21:0] oa [3] = '{22'h603f, 22'h6040, 22'h603f};
    logic [31:0] ox [3] = '{32'h11, 32'h22, 32'h33};
    int fail_count = 0;
    int compares = 0;

    always #20 ref_clk = ~ref_clk;

    peripheral_frame_decode_protect #(
        .PART_CODE(16'h1234), // Arbitrary value
        .REV_CODE(16'h0042) // Arbitrary value
    ) i_dut (
        .ref_clk(ref_clk),
        .srst(srst),
        .cpu_req(cpu_req),
        .cpu_acc(cpu_acc),
        .cpu_ack(cpu_ack),
        .cpu_rdata(cpu_rdata),
        .cpu_rejected(cpu_rejected),
        .write_allow_instr(write_allow_instr),
        .write_disallow_instr(write_disallow_instr),
        .reset_pin_status(reset_pin_status),
        .vector_map_config(vector_map_config),
        .security_locked(security_locked),
        .write_allow(write_allow),
        .per_req(per_req),
        .per_acc(per_acc),
        .per_done(per_done),
        .per_rdata(per_rdata)
    );

    periph_model i_peer (
        .ref_clk(ref_clk),
        .srst(srst),
        .lat(lat),
        .per_req(per_req),
        .per_acc(per_acc),
        .per_done(per_done),
        .per_rdata(per_rdata)
    );

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    // One processor access, held until acknowledged
    task automatic xfer(input logic w, input logic wd,
        input logic [21:0] a, input logic [31:0] d);
        int n;
        @(negedge ref_clk);
        cpu_acc = {w, wd, a, d};
        cpu_req = 1'b1;
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (cpu_ack !== 1'b1 && n < 200);
        if (n >= 200)
            fail_count++;
        rd_v = cpu_rdata;
        rj_v = cpu_rejected;
        cpu_req = 1'b0;
    endtask : xfer

    // Pulse the allow or disallow strobe
    task automatic strobe(input logic al);
        @(negedge ref_clk);
        write_allow_instr = al;
        write_disallow_instr = !al;
        @(negedge ref_clk);
        write_allow_instr = 1'b0;
        write_disallow_instr = 1'b0;
        @(negedge ref_clk);
    endtask : strobe

    task test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (10) @(negedge ref_clk);
        srst = 1'b0;
        xfer(0, 1, `CFG_LO_ADDR, 0);
        `CHK("cfg", 32'h000f_0063, rd_v)
        xfer(0, 0, `WIN_BASE_ADDR, 0);
        `CHK("base", 32'h0100, rd_v)
        xfer(0, 0, `WIN_SIZE_ADDR, 0);
        `CHK("size", 32'h00ff, rd_v)
        xfer(0, 1, `IDENT_LO_ADDR, 0);
        `CHK("ident", 32'h0042_1234, rd_v)
        reset_pin_status = 1'b0;
        vector_map_config = 1'b1;
        xfer(1, 1, `CFG_LO_ADDR, 0);
        `CHK("cfg locked", 1'b1, rj_v)
        xfer(0, 1, `CFG_LO_ADDR, 0);
        `CHK("cfg pins", 32'h000f_004b, rd_v)
        strobe(1);
        `CHK("allow", 1'b1, write_allow)
        xfer(1, 1, `CFG_LO_ADDR, 0);
        xfer(0, 1, `CFG_LO_ADDR, 0);
        `CHK("cfg zero", 32'h0007_0048, rd_v)
        xfer(1, 1, `CFG_LO_ADDR, 32'hffff_ffff);
        xfer(0, 1, `CFG_LO_ADDR, 0);
        `CHK("cfg ones", 32'h000f_80cb, rd_v)
        security_locked = 1'b1;
        xfer(1, 0, `FLASH_LO, 32'h1);
        `CHK("flash lock", 1'b1, rj_v)
        security_locked = 1'b0;
        strobe(0);
        `CHK("allow off", 1'b0, write_allow)
        foreach (ga[i])
        begin
            xfer(1, 0, ga[i], 0);
            `CHK("guard", gx[i], rj_v)
        end
        xfer(0, 0, 22'haf0, 0);
        `CHK("hole", 32'h0, rd_v)
        // Frame one, even address for the wide access
        xfer(1, 1, 22'h6000, 32'hcafe_1234);
        xfer(0, 1, 22'h6000, 0);
        `CHK("pf1 wide", 32'hcafe_1234, rd_v)
        xfer(0, 0, 22'h6001, 0);
        `CHK("pf1 half", 32'h0000_cafe, rd_v)
        xfer(0, 0, 22'h6200, 0);
        `CHK("pf1 hole", 32'h0, rd_v)
        xfer(1, 0, 22'h7040, 32'h5555);
        xfer(1, 1, 22'h7040, 32'haaaa_aaaa);
        xfer(0, 0, 22'h7040, 0);
        `CHK("pf2 half", 32'h5555, rd_v)
        xfer(0, 1, 22'h7040, 0);
        `CHK("pf2 wide", 32'h0, rd_v)
        // Window of 64 words at 0x6000, slow peripheral
        strobe(1);
        xfer(1, 0, `WIN_BASE_ADDR, 32'h0180);
        xfer(1, 0, `WIN_SIZE_ADDR, 32'h0);
        lat = 4'h8;
        for (int k = 0; k < 3; k++)
        begin
            if (k == 2)
                xfer(1, 1, `CFG_LO_ADDR, 0);
            xfer(1, 0, 22'h6100, 32'h1);
            xfer(1, 0, oa[k], 32'h11 * (k + 1));
            xfer(0, 0, oa[k], 0);
            `CHK("order", ox[k], rd_v)
        end
        test_done;
    end

    // Cut a hung run short
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        test_done;
    end
endmodule : test_peripheral_frame_decode_protect
